// ### inc/mma_pkg.sv
// ****************************************
// Memory addressing package
// ****************************************
package mma_pkg;
	// Widths
	localparam int PC_W = 13;
	localparam int ROM_W = 14;
	localparam int TP_W = 12;
	localparam int RAM_W = 9;
	localparam int ARG_W = 11;
	localparam int STACK_LEVELS = 13;
	// Fixed program addresses
	localparam logic [12:0] RESET_VECTOR = 13'h0000;
	localparam logic [12:0] IRQ_FIRST = 13'h0002;
	localparam logic [12:0] IRQ_LAST = 13'h000C;
	localparam logic [12:0] IRQ_RESERVED = 13'h0004;
	localparam logic [12:0] SHORT_CALL_FIRST = 13'h000E;
	localparam logic [12:0] SHORT_CALL_LAST = 13'h0086;
	localparam logic [12:0] SHORT_CALL_OFFSET = 13'h0006;
	localparam logic [12:0] LONG_CALL_LAST = 13'h07FF;
	localparam logic [2:0] IRQ_SEL_MAX = 3'h5;
	// Data RAM bank limits (exclusive upper ends)
	localparam logic [7:0] RAM_BANK0_END = 8'hF4;
	localparam logic [7:0] RAM_BANK1_END = 8'h80;
	// Register offsets
	localparam logic [3:0] OFF_LOW_PTR = 4'h0;
	localparam logic [3:0] OFF_HIGH_PTR = 4'h1;
	localparam logic [3:0] OFF_STACK_PTR = 4'h2;
	localparam logic [3:0] OFF_TP_LOW = 4'h3;
	localparam logic [3:0] OFF_TP_MID = 4'h4;
	localparam logic [3:0] OFF_TP_HIGH = 4'h5;
	localparam logic [3:0] OFF_ROM_BANK = 4'h6;
	localparam logic [3:0] OFF_RAM_BANK = 4'h7;
	localparam logic [3:0] OFF_PORT4 = 4'h8;
	localparam logic [3:0] OFF_ACC_DATA = 4'h9;
	// Field positions and reset values
	localparam int RAM_BANK_BIT = 3;
	localparam logic [3:0] NIBBLE_RST = 4'h0;
	localparam logic [3:0] NIBBLE_ONE = 4'h1;
	localparam logic [1:0] ROM_BANK_FIELD_MAX = 2'h2;
	// Operation codes
	typedef enum logic [4:0] {
		OP_STEP = 5'b00000,
		OP_SHORT_BRANCH = 5'b00001,
		OP_SHORT_CALL = 5'b00010,
		OP_LONG_CALL = 5'b00011,
		OP_RETURN = 5'b00100,
		OP_IRQ = 5'b00101,
		OP_TABLE_READ_LOW = 5'b00110,
		OP_TABLE_READ_HIGH_INC = 5'b00111,
		OP_LOAD_ACC_FROM_MEM = 5'b01000,
		OP_STORE_ACC_TO_MEM = 5'b01001,
		OP_STORE_MEM_INC = 5'b01010,
		OP_LOAD_DIRECT = 5'b01011,
		OP_STORE_DIRECT = 5'b01100,
		OP_LOAD_ZERO_PAGE = 5'b01101,
		OP_STORE_ZERO_PAGE = 5'b01110,
		OP_PORT_BIT_SET = 5'b01111,
		OP_PORT_BIT_CLEAR = 5'b10000,
		OP_PORT_BIT_TEST = 5'b10001
	} mma_op_t;
endpackage

// ### verilog/mma_return_stack.sv
`timescale 1ns/10ps
// ****************************************
// Return stack, one entry per level
// ****************************************
module mma_return_stack (
	// Clock
	input wire logic clk,
	// Write side
	input wire logic push,
	input wire logic [3:0] wr_level,
	input wire logic [12:0] wr_data,
	// Read side
	input wire logic [3:0] rd_level,
	output logic [12:0] rd_data
);
	// Entries carry no reset; software owns the contents
	logic [12:0] level_reg [mma_pkg::STACK_LEVELS];

	// One write port per level
	genvar i;
	generate
		for (i = 0; i < mma_pkg::STACK_LEVELS; i++) begin : g_level
			always_ff @(posedge clk) begin
				// Levels past the top are silently dropped
				if (push && wr_level == 4'(i)) begin
					level_reg[i] <= wr_data;
				end
			end
		end
	endgenerate

	// Read out of range gives the reset vector
	always_comb begin
		if (rd_level < 4'(mma_pkg::STACK_LEVELS)) begin
			rd_data = level_reg[rd_level];
		end else begin
			rd_data = mma_pkg::RESET_VECTOR;
		end
	end
endmodule

// ### verilog/mma_core.sv
// Added by the designer: the register addresses and strobed register access.
`timescale 1ns/10ps
// ****************************************
// Memory addressing core
// ****************************************
// Notes on behaviour
// - Low pointer picks port 4 bit
// - Load/store address from pointer pair
// - Four-bit stack pointer, untouched by reset
// - Call or interrupt decrements; return increments
// - Twelve-bit table pointer into program ROM
// - Fetch starts at zero after reset
// - Interrupt vectors even, 0002h to 000Ch
// - Short call targets 000Eh..0086h step eight
// - Long call targets below 0800h
// - Table reads only hit upper bank
// - Program ROM is four 4K banks
// - Upper half mapped by bank field
// - Thirteen-bit counter; reset clears counter, bank
// - Low read nibble; high read increments
// - RAM banks 244 and 128 nibbles
// - Bank select bit picks RAM bank
// - Indirect address from pointer pair
// - Direct address from second byte
// - Zero page uses bank 0, low nibble
// - Thirteen-level stack saves, restores counter
// - Taken short branch replaces low six
// - Untaken short branch advances by one
// - Branch taken only when flag set
module mma_core (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Register port
	input wire logic [3:0] reg_addr,
	input wire logic [3:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [3:0] reg_rdata,
	// Instruction step
	input wire logic op_valid,
	input wire mma_pkg::mma_op_t op_code,
	input wire logic [10:0] op_arg,
	input wire logic [1:0] op_len,
	input wire logic [2:0] irq_sel,
	input wire logic status_flag,
	input wire logic [3:0] acc_in,
	// Program ROM
	output logic [13:0] rom_addr,
	input wire logic [7:0] rom_byte,
	output logic [12:0] pc,
	// Data RAM
	output logic [8:0] ram_addr,
	output logic ram_we,
	output logic ram_re,
	output logic [3:0] ram_wdata,
	// Accumulator and port results
	output logic [3:0] acc_data,
	output logic acc_load,
	output logic [3:0] port4_out,
	output logic port_test_flag
);
	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [12:0] pc;
		logic [3:0] low_pointer_nibble;
		logic [3:0] high_pointer_nibble;
		logic [11:0] table_pointer;
		logic [3:0] rom_bank_select;
		logic [3:0] ram_bank_port;
		logic [3:0] port4;
		logic [3:0] rd_data;
		logic [8:0] ram_addr;
		logic ram_we;
		logic ram_re;
		logic [3:0] ram_wdata;
		logic [3:0] acc_data;
		logic acc_load;
		logic test_flag;
	} mma_state_t;

	mma_state_t s_reg; // Registered state
	mma_state_t s_next; // Next state
	logic [3:0] stack_level_pointer_reg; // Kept outside the struct: no reset
	logic [3:0] stack_level_pointer_next; // Next stack level
	logic push; // Save return address
	logic [12:0] push_data; // Return address to save
	logic [12:0] pop_data; // Restored return address
	logic table_op; // Table read in progress
	logic ram_bank1; // Bank select bit

	// ****************************************
	// Decoders
	// ****************************************
	// Upper half bank field to physical bank
	function automatic logic [1:0] upper_bank(input logic [1:0] field);
		// Field 11 is outside the map; held at bank 3
		if (field > mma_pkg::ROM_BANK_FIELD_MAX) begin
			upper_bank = 2'h3;
		end else begin
			upper_bank = field + 2'h1;
		end
	endfunction

	// Data RAM range check per bank
	function automatic logic ram_in_range(input logic [8:0] a);
		if (a[8]) begin
			ram_in_range = a[7:0] < mma_pkg::RAM_BANK1_END;
		end else begin
			ram_in_range = a[7:0] < mma_pkg::RAM_BANK0_END;
		end
	endfunction

	assign ram_bank1 = s_reg.ram_bank_port[mma_pkg::RAM_BANK_BIT];
	assign table_op = op_valid && (op_code == mma_pkg::OP_TABLE_READ_LOW
		|| op_code == mma_pkg::OP_TABLE_READ_HIGH_INC);

	// ****************************************
	// Program ROM address
	// ****************************************
	always_comb begin
		if (table_op) begin
			rom_addr = {upper_bank(s_reg.rom_bank_select[1:0]), s_reg.table_pointer};
		end else if (s_reg.pc[12]) begin
			rom_addr = {upper_bank(s_reg.rom_bank_select[1:0]), s_reg.pc[11:0]};
		end else begin
			rom_addr = {2'h0, s_reg.pc[11:0]};
		end
	end

	// Return stack, indexed by the level pointer
	mma_return_stack u_stack (
		.clk(clk),
		.push(push),
		.wr_level(stack_level_pointer_reg),
		.wr_data(push_data),
		.rd_level(stack_level_pointer_reg + 4'h1),
		.rd_data(pop_data)
	);

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		s_next = s_reg;
		stack_level_pointer_next = stack_level_pointer_reg;
		push = 1'b0;
		push_data = s_reg.pc;
		s_next.ram_we = 1'b0;
		s_next.ram_re = 1'b0;
		s_next.acc_load = 1'b0;
		s_next.rd_data = mma_pkg::NIBBLE_RST;
		// Register reads, answered next cycle
		if (reg_read) begin
			case (reg_addr)
				mma_pkg::OFF_LOW_PTR: s_next.rd_data = s_reg.low_pointer_nibble;
				mma_pkg::OFF_HIGH_PTR: s_next.rd_data = s_reg.high_pointer_nibble;
				mma_pkg::OFF_STACK_PTR: begin
					// Only visible in RAM bank 0
					if (!ram_bank1) begin
						s_next.rd_data = stack_level_pointer_reg;
					end
				end
				mma_pkg::OFF_TP_LOW: s_next.rd_data = ram_bank1 ? 4'h0 : s_reg.table_pointer[3:0];
				mma_pkg::OFF_TP_MID: s_next.rd_data = ram_bank1 ? 4'h0 : s_reg.table_pointer[7:4];
				mma_pkg::OFF_TP_HIGH: s_next.rd_data = ram_bank1 ? 4'h0 : s_reg.table_pointer[11:8];
				mma_pkg::OFF_ROM_BANK: s_next.rd_data = s_reg.rom_bank_select;
				mma_pkg::OFF_RAM_BANK: s_next.rd_data = s_reg.ram_bank_port;
				mma_pkg::OFF_PORT4: s_next.rd_data = s_reg.port4;
				mma_pkg::OFF_ACC_DATA: s_next.rd_data = s_reg.acc_data;
				default: s_next.rd_data = mma_pkg::NIBBLE_RST;
			endcase
		end
		// Register writes; the operation below wins a clash
		if (reg_write) begin
			case (reg_addr)
				mma_pkg::OFF_LOW_PTR: s_next.low_pointer_nibble = reg_wdata;
				mma_pkg::OFF_HIGH_PTR: s_next.high_pointer_nibble = reg_wdata;
				mma_pkg::OFF_STACK_PTR: begin
					if (!ram_bank1) begin
						stack_level_pointer_next = reg_wdata;
					end
				end
				mma_pkg::OFF_TP_LOW: begin
					// Ignored outside RAM bank 0
					if (!ram_bank1) begin
						s_next.table_pointer[3:0] = reg_wdata;
					end
				end
				mma_pkg::OFF_TP_MID: begin
					if (!ram_bank1) begin
						s_next.table_pointer[7:4] = reg_wdata;
					end
				end
				mma_pkg::OFF_TP_HIGH: begin
					if (!ram_bank1) begin
						s_next.table_pointer[11:8] = reg_wdata;
					end
				end
				mma_pkg::OFF_ROM_BANK: s_next.rom_bank_select = reg_wdata;
				mma_pkg::OFF_RAM_BANK: s_next.ram_bank_port = reg_wdata;
				mma_pkg::OFF_PORT4: s_next.port4 = reg_wdata;
				default: begin
					// Unmapped writes are dropped
				end
			endcase
		end
		// Instruction step
		if (op_valid) begin
			s_next.pc = s_reg.pc + 13'(op_len);
			case (op_code)
				mma_pkg::OP_SHORT_BRANCH: begin
					// Taken only on a set flag
					if (status_flag) begin
						s_next.pc = {s_reg.pc[12:6], op_arg[5:0]};
					end else begin
						s_next.pc = s_reg.pc + 13'h0001;
					end
				end
				mma_pkg::OP_SHORT_CALL: begin
					push = 1'b1;
					push_data = s_reg.pc + 13'h0001;
					stack_level_pointer_next = stack_level_pointer_reg - 4'h1;
					// Slot zero lands on the last entry
					if (op_arg[3:0] == 4'h0) begin
						s_next.pc = mma_pkg::SHORT_CALL_LAST;
					end else begin
						s_next.pc = {6'h00, op_arg[3:0], 3'h0} + mma_pkg::SHORT_CALL_OFFSET;
					end
				end
				mma_pkg::OP_LONG_CALL: begin
					push = 1'b1;
					push_data = s_reg.pc + 13'h0002;
					stack_level_pointer_next = stack_level_pointer_reg - 4'h1;
					s_next.pc = {2'h0, op_arg};
				end
				mma_pkg::OP_RETURN: begin
					s_next.pc = pop_data;
					stack_level_pointer_next = stack_level_pointer_reg + 4'h1;
				end
				mma_pkg::OP_IRQ: begin
					// Current counter is the resume point
					push = 1'b1;
					push_data = s_reg.pc;
					stack_level_pointer_next = stack_level_pointer_reg - 4'h1;
					if (irq_sel > mma_pkg::IRQ_SEL_MAX) begin
						s_next.pc = mma_pkg::IRQ_RESERVED;
					end else begin
						s_next.pc = mma_pkg::IRQ_FIRST + {9'h000, irq_sel, 1'b0};
					end
				end
				mma_pkg::OP_TABLE_READ_LOW: begin
					s_next.acc_data = rom_byte[3:0];
					s_next.acc_load = 1'b1;
				end
				mma_pkg::OP_TABLE_READ_HIGH_INC: begin
					s_next.acc_data = rom_byte[7:4];
					s_next.acc_load = 1'b1;
					s_next.table_pointer = s_reg.table_pointer + 12'h001;
				end
				mma_pkg::OP_LOAD_ACC_FROM_MEM, mma_pkg::OP_STORE_ACC_TO_MEM,
				mma_pkg::OP_STORE_MEM_INC: begin
					s_next.ram_addr = {ram_bank1, s_reg.high_pointer_nibble,
						s_reg.low_pointer_nibble};
					s_next.ram_re = (op_code == mma_pkg::OP_LOAD_ACC_FROM_MEM)
						&& ram_in_range(s_next.ram_addr);
					s_next.ram_we = (op_code != mma_pkg::OP_LOAD_ACC_FROM_MEM)
						&& ram_in_range(s_next.ram_addr);
					s_next.ram_wdata = acc_in;
					if (op_code == mma_pkg::OP_STORE_MEM_INC) begin
						s_next.low_pointer_nibble = s_reg.low_pointer_nibble + mma_pkg::NIBBLE_ONE;
					end
				end
				mma_pkg::OP_LOAD_DIRECT, mma_pkg::OP_STORE_DIRECT: begin
					s_next.ram_addr = {ram_bank1, op_arg[7:0]};
					s_next.ram_re = (op_code == mma_pkg::OP_LOAD_DIRECT) && ram_in_range(s_next.ram_addr);
					s_next.ram_we = (op_code == mma_pkg::OP_STORE_DIRECT) && ram_in_range(s_next.ram_addr);
					s_next.ram_wdata = acc_in;
				end
				mma_pkg::OP_LOAD_ZERO_PAGE, mma_pkg::OP_STORE_ZERO_PAGE: begin
					// Bank select bit plays no part here
					s_next.ram_addr = {5'h00, op_arg[3:0]};
					s_next.ram_re = (op_code == mma_pkg::OP_LOAD_ZERO_PAGE);
					s_next.ram_we = (op_code == mma_pkg::OP_STORE_ZERO_PAGE);
					s_next.ram_wdata = acc_in;
				end
				mma_pkg::OP_PORT_BIT_SET: begin
					// Pointer values above 3 select no pin
					if (s_reg.low_pointer_nibble < 4'h4) begin
						s_next.port4[s_reg.low_pointer_nibble[1:0]] = 1'b1;
					end
				end
				mma_pkg::OP_PORT_BIT_CLEAR: begin
					if (s_reg.low_pointer_nibble < 4'h4) begin
						s_next.port4[s_reg.low_pointer_nibble[1:0]] = 1'b0;
					end
				end
				mma_pkg::OP_PORT_BIT_TEST: begin
					s_next.test_flag = (s_reg.low_pointer_nibble < 4'h4)
						&& s_reg.port4[s_reg.low_pointer_nibble[1:0]];
				end
				default: begin
					// Plain step: counter advance only
				end
			endcase
		end
	end

	// ****************************************
	// State registers
	// ****************************************
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	// Stack level survives reset on purpose
	always_ff @(posedge clk) begin
		stack_level_pointer_reg <= stack_level_pointer_next;
	end

	// Outputs
	assign reg_rdata = s_reg.rd_data;
	assign pc = s_reg.pc;
	assign ram_addr = s_reg.ram_addr;
	assign ram_we = s_reg.ram_we;
	assign ram_re = s_reg.ram_re;
	assign ram_wdata = s_reg.ram_wdata;
	assign acc_data = s_reg.acc_data;
	assign acc_load = s_reg.acc_load;
	assign port4_out = s_reg.port4;
	assign port_test_flag = s_reg.test_flag;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_reset_fetch_zero: assert property ($fell(rst) |-> pc == mma_pkg::RESET_VECTOR
		&& s_reg.rom_bank_select == 4'h0) else $error("counter or bank not zero after reset");
	a_branch_taken: assert property (op_valid && op_code == mma_pkg::OP_SHORT_BRANCH && status_flag
		|=> pc == {$past(pc[12:6]), $past(op_arg[5:0])}) else $error("short branch target wrong");
	a_branch_skip: assert property (op_valid && op_code == mma_pkg::OP_SHORT_BRANCH && !status_flag
		|=> pc == $past(pc) + 13'h0001) else $error("untaken branch not plus one");
	a_short_call_slot: assert property (op_valid && op_code == mma_pkg::OP_SHORT_CALL
		|=> pc >= mma_pkg::SHORT_CALL_FIRST && pc <= mma_pkg::SHORT_CALL_LAST && pc[2:0] == 3'h6)
		else $error("short call off its slots");
	a_long_call_range: assert property (op_valid && op_code == mma_pkg::OP_LONG_CALL
		|=> pc <= mma_pkg::LONG_CALL_LAST) else $error("long call out of range");
	a_irq_vector: assert property (op_valid && op_code == mma_pkg::OP_IRQ
		|=> pc >= mma_pkg::IRQ_FIRST && pc <= mma_pkg::IRQ_LAST && !pc[0])
		else $error("interrupt vector wrong");
	a_stack_call_dec: assert property (op_valid && (op_code == mma_pkg::OP_IRQ
		|| op_code == mma_pkg::OP_LONG_CALL || op_code == mma_pkg::OP_SHORT_CALL)
		|=> stack_level_pointer_reg == $past(stack_level_pointer_reg) - 4'h1)
		else $error("stack level not decremented");
	a_table_high: assert property (op_valid && op_code == mma_pkg::OP_TABLE_READ_HIGH_INC
		|=> acc_load && acc_data == $past(rom_byte[7:4])
		&& s_reg.table_pointer == $past(s_reg.table_pointer) + 12'h001)
		else $error("high table read wrong");
	a_table_upper: assert property (table_op |-> rom_addr[13:12] != 2'h0)
		else $error("table read left upper half");
	a_store_inc: assert property (op_valid && op_code == mma_pkg::OP_STORE_MEM_INC && !reg_write
		|=> s_reg.low_pointer_nibble == $past(s_reg.low_pointer_nibble) + 4'h1) else $error("pointer not bumped");
	a_zero_page: assert property (op_valid && op_code == mma_pkg::OP_STORE_ZERO_PAGE
		|=> ram_we && ram_addr[8:4] == 5'h00) else $error("zero page left bank 0");
	a_call_return: assert property (op_valid && op_code == mma_pkg::OP_LONG_CALL ##1
		op_valid && op_code == mma_pkg::OP_RETURN |=> pc == $past(pc, 2) + 13'h0002)
		else $error("return address lost");

	c_irq_taken: cover property (op_valid && op_code == mma_pkg::OP_IRQ);
	c_call_then_return: cover property (op_valid && op_code == mma_pkg::OP_SHORT_CALL ##[1:8]
		op_valid && op_code == mma_pkg::OP_RETURN);
	c_table_pair: cover property (op_valid && op_code == mma_pkg::OP_TABLE_READ_LOW ##1
		op_valid && op_code == mma_pkg::OP_TABLE_READ_HIGH_INC);
	c_branch_taken: cover property (op_valid && op_code == mma_pkg::OP_SHORT_BRANCH && status_flag);
endmodule

// ### verification/mma_mem_model.sv
`timescale 1ns/10ps
// ****************************************
// Program ROM and data RAM model
// ****************************************
module mma_mem_model (
	// Clock
	input wire logic clk,
	// Program ROM
	input wire logic [13:0] rom_addr,
	output logic [7:0] rom_byte,
	// Data RAM
	input wire logic [8:0] ram_addr,
	input wire logic ram_we,
	input wire logic [3:0] ram_wdata
);
	// Nibble array covering both banks
	logic [3:0] ram [0:511];
	// Byte built from bank and low address bits, so each bank reads back differently
	assign rom_byte = {rom_addr[13:12], rom_addr[5:0]};
	// Writes land only inside the populated part of each bank
	always @(posedge clk) begin
		if (ram_we && (ram_addr[8] ? ram_addr[7:0] < 8'h80 : ram_addr[7:0] < 8'hF4)) begin
			ram[ram_addr] <= ram_wdata;
		end
	end
endmodule

// ### verification/mma_core_tb.sv
`timescale 1ns/10ps
// ****************************************
// Memory addressing core testbench
// ****************************************
module mma_core_tb;
	// Design inputs, all valued at time zero
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] reg_addr = 4'h0;
	logic [3:0] reg_wdata = 4'h0;
	logic reg_write = 1'b0;
	logic reg_read = 1'b0;
	logic op_valid = 1'b0;
	mma_pkg::mma_op_t op_code = mma_pkg::OP_STEP;
	logic [10:0] op_arg = 11'h000;
	logic [1:0] op_len = 2'h1;
	logic [2:0] irq_sel = 3'h0;
	logic status_flag = 1'b0;
	logic [3:0] acc_in = 4'hA;
	// Design outputs
	logic [3:0] reg_rdata;
	logic [13:0] rom_addr;
	logic [7:0] rom_byte;
	logic [12:0] pc;
	logic [8:0] ram_addr;
	logic ram_we;
	logic ram_re;
	logic [3:0] ram_wdata;
	logic [3:0] acc_data;
	logic acc_load;
	logic [3:0] port4_out;
	logic port_test_flag;
	// Bench state
	int error_cnt = 0;
	int check_count = 0;
	int cyc = 0;
	logic sf_v = 1'b0;
	logic [2:0] irq_v = 3'h0;
	logic [13:0] last_rom;
	logic [15:0] p;
	logic [3:0] ns [3] = '{4'h0, 4'h1, 4'hF};
	logic [15:0] ts [3] = '{16'h0086, 16'h000E, 16'h007E};

	mma_core dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
		.reg_read(reg_read), .reg_rdata(reg_rdata), .op_valid(op_valid), .op_code(op_code), .op_arg(op_arg),
		.op_len(op_len), .irq_sel(irq_sel), .status_flag(status_flag), .acc_in(acc_in), .rom_addr(rom_addr),
		.rom_byte(rom_byte), .pc(pc), .ram_addr(ram_addr), .ram_we(ram_we), .ram_re(ram_re), .ram_wdata(ram_wdata),
		.acc_data(acc_data), .acc_load(acc_load), .port4_out(port4_out), .port_test_flag(port_test_flag));

	mma_mem_model mem (.clk(clk), .rom_addr(rom_addr), .rom_byte(rom_byte), .ram_addr(ram_addr),
		.ram_we(ram_we), .ram_wdata(ram_wdata));

	// ****************************************
	// Clock and hang guard
	// ****************************************
	initial begin
		forever #5 clk = ~clk;
	end
	// Whole run is well under a thousand cycles, so this only trips on a hang
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			complete_run();
		end
	end

	// ****************************************
	// Shared tasks
	// ****************************************
	// Compare one value, four-state exact
	task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		check_count++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	// One-cycle register write
	task wr(input logic [3:0] a, input logic [3:0] d);
		@(posedge clk);
		reg_write <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_write <= 1'b0;
	endtask
	// One-cycle read, data taken in the following cycle only
	task rd_chk(input string nm, input logic [3:0] a, input logic [3:0] e);
		@(posedge clk);
		reg_read <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_read <= 1'b0;
		#1;
		chk(nm, 16'(e), 16'(reg_rdata));
	endtask
	// One instruction; ROM address caught in its own cycle, results after the edge
	task do_op(input mma_pkg::mma_op_t c, input logic [10:0] a, input logic [1:0] l);
		@(posedge clk);
		op_valid <= 1'b1;
		op_code <= c;
		op_arg <= a;
		op_len <= l;
		status_flag <= sf_v;
		irq_sel <= irq_v;
		#1;
		last_rom = rom_addr;
		@(posedge clk);
		op_valid <= 1'b0;
		#1;
	endtask
	// Counts, verdict and end of run
	task complete_run();
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		#1;
		chk("pc reset", 16'h0000, 16'(pc));
		rd_chk("rom bank reset", 4'h6, 4'h0);
		rd_chk("unmapped", 4'hF, 4'h0);
		// Stack level loaded before any call
		wr(4'h2, 4'hC);
		rd_chk("stack ptr", 4'h2, 4'hC);
		do_op(mma_pkg::OP_STEP, 11'h000, 2'h2);
		chk("pc step", 16'h0002, 16'(pc));
		do_op(mma_pkg::OP_LONG_CALL, 11'h123, 2'h2);
		chk("pc long call", 16'h0123, 16'(pc));
		rd_chk("sp after call", 4'h2, 4'hB);
		do_op(mma_pkg::OP_RETURN, 11'h000, 2'h1);
		chk("pc return", 16'h0004, 16'(pc));
		rd_chk("sp after return", 4'h2, 4'hC);
		// Short call entries at both ends and the one below the top
		p = 16'h0004;
		for (int i = 0; i < 3; i++) begin
			do_op(mma_pkg::OP_SHORT_CALL, 11'(ns[i]), 2'h1);
			chk("pc short call", ts[i], 16'(pc));
			do_op(mma_pkg::OP_RETURN, 11'h000, 2'h1);
			p = p + 16'h0001;
			chk("pc short return", p, 16'(pc));
		end
		// Every interrupt source, current pc saved
		for (int s = 0; s < 6; s++) begin
			irq_v = 3'(s);
			do_op(mma_pkg::OP_IRQ, 11'h000, 2'h1);
			chk("pc irq vector", 16'(2 + 2 * s), 16'(pc));
			do_op(mma_pkg::OP_RETURN, 11'h000, 2'h1);
			chk("pc irq return", 16'h0007, 16'(pc));
		end
		// Source code past the last one falls back to the spare slot
		irq_v = 3'h7;
		do_op(mma_pkg::OP_IRQ, 11'h000, 2'h1);
		chk("pc irq spare", 16'h0004, 16'(pc));
		do_op(mma_pkg::OP_RETURN, 11'h000, 2'h1);
		chk("pc irq spare return", 16'h0007, 16'(pc));
		// Top long call entry, then short branch taken and not taken
		do_op(mma_pkg::OP_LONG_CALL, 11'h7FF, 2'h2);
		chk("pc long call top", 16'h07FF, 16'(pc));
		sf_v = 1'b1;
		do_op(mma_pkg::OP_SHORT_BRANCH, 11'h02A, 2'h1);
		chk("branch taken", 16'h07EA, 16'(pc));
		sf_v = 1'b0;
		do_op(mma_pkg::OP_SHORT_BRANCH, 11'h015, 2'h2);
		chk("branch skipped", 16'h07EB, 16'(pc));
		do_op(mma_pkg::OP_RETURN, 11'h000, 2'h1);
		chk("pc return top", 16'h0009, 16'(pc));
		// Call and return with no idle cycle: return must see the entry just pushed
		@(posedge clk);
		op_valid <= 1'b1;
		op_code <= mma_pkg::OP_LONG_CALL;
		op_arg <= 11'h456;
		op_len <= 2'h2;
		@(posedge clk);
		op_code <= mma_pkg::OP_RETURN;
		@(posedge clk);
		op_valid <= 1'b0;
		#1;
		chk("pc back to back", 16'h000B, 16'(pc));
		// Table reads through each upper bank, pointer loaded from RAM bank 0
		wr(4'h4, 4'h7);
		wr(4'h5, 4'h7);
		for (int b = 0; b < 3; b++) begin
			wr(4'h3, 4'h7);
			wr(4'h6, 4'(b));
			do_op(mma_pkg::OP_TABLE_READ_LOW, 11'h000, 2'h1);
			chk("table rom addr", 16'({2'(b + 1), 12'h777}), 16'(last_rom));
			chk("table low", 16'h0007, 16'(acc_data));
			do_op(mma_pkg::OP_TABLE_READ_HIGH_INC, 11'h000, 2'h1);
			chk("table high", 16'({2'(b + 1), 2'h3}), 16'(acc_data));
			chk("table load", 16'h0001, 16'(acc_load));
		end
		rd_chk("table ptr inc", 4'h3, 4'h8);
		// Indirect store into bank 1, with pointer access locked out there
		wr(4'h0, 4'h3);
		wr(4'h1, 4'h4);
		wr(4'h7, 4'h8);
		do_op(mma_pkg::OP_STORE_ACC_TO_MEM, 11'h000, 2'h1);
		chk("indirect addr", 16'h0143, 16'(ram_addr));
		chk("indirect we", 16'h0001, 16'(ram_we));
		wr(4'h2, 4'h0);
		rd_chk("sp locked", 4'h2, 4'h0);
		rd_chk("table ptr locked", 4'h3, 4'h0);
		chk("ram stored", 16'h000A, 16'(mem.ram[9'h143]));
		do_op(mma_pkg::OP_STORE_MEM_INC, 11'h000, 2'h1);
		rd_chk("low ptr inc", 4'h0, 4'h4);
		// Direct addressing at the bank 1 boundary, zero page ignores the bank
		do_op(mma_pkg::OP_STORE_DIRECT, 11'h080, 2'h2);
		chk("out of range we", 16'h0000, 16'(ram_we));
		do_op(mma_pkg::OP_STORE_DIRECT, 11'h07F, 2'h2);
		chk("direct addr b1", 16'h017F, 16'(ram_addr));
		do_op(mma_pkg::OP_STORE_ZERO_PAGE, 11'h0F5, 2'h2);
		chk("zero page addr", 16'h0005, 16'(ram_addr));
		do_op(mma_pkg::OP_LOAD_ZERO_PAGE, 11'h0F5, 2'h2);
		chk("zero page re", 16'h0001, 16'(ram_re));
		wr(4'h7, 4'h0);
		do_op(mma_pkg::OP_STORE_DIRECT, 11'h023, 2'h2);
		chk("direct addr b0", 16'h0023, 16'(ram_addr));
		// Loads: bank 0 end, then indirect through the pointer pair
		do_op(mma_pkg::OP_LOAD_DIRECT, 11'h0F4, 2'h2);
		chk("out of range re", 16'h0000, 16'(ram_re));
		do_op(mma_pkg::OP_LOAD_DIRECT, 11'h0F3, 2'h2);
		chk("direct re b0", 16'h0001, 16'(ram_re));
		do_op(mma_pkg::OP_LOAD_ACC_FROM_MEM, 11'h000, 2'h1);
		chk("indirect load addr", 16'h0044, 16'(ram_addr));
		chk("indirect re", 16'h0001, 16'(ram_re));
		// Port 4 bits indexed by the low pointer
		wr(4'h0, 4'h0);
		do_op(mma_pkg::OP_PORT_BIT_SET, 11'h000, 2'h1);
		chk("port bit0", 16'h0001, 16'(port4_out));
		do_op(mma_pkg::OP_PORT_BIT_TEST, 11'h000, 2'h1);
		chk("port test", 16'h0001, 16'(port_test_flag));
		wr(4'h0, 4'h2);
		do_op(mma_pkg::OP_PORT_BIT_SET, 11'h000, 2'h1);
		chk("port bit2", 16'h0005, 16'(port4_out));
		do_op(mma_pkg::OP_PORT_BIT_CLEAR, 11'h000, 2'h1);
		chk("port clear", 16'h0001, 16'(port4_out));
		// Mid-run reset: counter and bank cleared, stack level kept
		@(posedge clk);
		rst <= 1'b1;
		@(posedge clk);
		rst <= 1'b0;
		#1;
		chk("pc rereset", 16'h0000, 16'(pc));
		rd_chk("rom bank rereset", 4'h6, 4'h0);
		rd_chk("sp kept", 4'h2, 4'hC);
		complete_run();
	end
endmodule
